// File: pkg/uei_map.svh
// Register offsets, field positions and timing counts of the endpoint interrupt block.
// Assumes a 100 MHz aclk; included by bare name wherever the map is needed.
`ifndef UEI_MAP_SVH
`define UEI_MAP_SVH
// ==========================================================================
// Device registers on the link (5-bit address, 8-bit data)
// ==========================================================================
`define UEI_R_IDX 5'h00
`define UEI_R_ST1 5'h01
`define UEI_R_ST2 5'h02
`define UEI_R_IEN1 5'h03
`define UEI_R_IEN2 5'h04
`define UEI_R_IRQ_CONTROL_A 5'h05
`define UEI_R_TXCSR 5'h06
`define UEI_R_RXCSR 5'h07
`define UEI_R_MAX_PACKET_SIZE 5'h08
`define UEI_R_TXDATA 5'h09
`define UEI_R_ISO 5'h0A
// Status register two field positions.
`define UEI_ST2_OVR 4
`define UEI_ST2_RST 5
`define UEI_ST2_RES 6
`define UEI_ST2_SUS 7
// Control register A field positions.
`define UEI_ICA_FUNC 0
`define UEI_ICA_SOF 1
// Packet-ready bit of the transmit and receive control words.
`define UEI_CSR_RDY 0
// Endpoint count and reset value of every device register.
`define UEI_NEP 5
`define UEI_REG_RST 8'h00
// ==========================================================================
// Controller registers on AXI4-Lite
// ==========================================================================
`define UEI_A_CMD 8'h00
`define UEI_A_STAT 8'h04
`define UEI_A_ISR 8'h08
`define UEI_CMD_WR 16
`define UEI_CMD_SVC 17
`define UEI_CMD_CLRI 18
`define UEI_AXI_OKAY 2'h0
`define UEI_AXI_SLVERR 2'h2
// ==========================================================================
// Timing
// ==========================================================================
`define UEI_CLK_NS 10
`define UEI_SUSP_NS 3000000
`define UEI_SE0_NS 2500000
`define UEI_SUSP_CYC ((`UEI_SUSP_NS + `UEI_CLK_NS - 1) / `UEI_CLK_NS)
`define UEI_SE0_CYC ((`UEI_SE0_NS + `UEI_CLK_NS - 1) / `UEI_CLK_NS)
`endif

// File: pkg/uei_pkg.sv
// Types shared by the two ends of the endpoint interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package uei_pkg;
  // ==========================================================================
  // Controller sequencer states
  // ==========================================================================
  typedef enum logic [3:0] {
    UEI_IDLE = 4'h0, // Waiting for a command.
    UEI_CRD = 4'h1, // Reading the transmit control word.
    UEI_CHK = 4'h2, // Judging whether buffer data may be written.
    UEI_AWR = 4'h3, // Writing one device register.
    UEI_ARD = 4'h4, // Reading one device register.
    UEI_RDN = 4'h5, // Capturing read data.
    UEI_SR1 = 4'h6, // Reading status one.
    UEI_SR2 = 4'h7, // Reading status two.
    UEI_SW1 = 4'h8, // Writing status one back.
    UEI_SW2 = 4'h9 // Writing status two back.
  } uei_hst_t;
endpackage

// File: pkg/uei_link_if.sv
// Register link between the processor-side controller and the USB function.
// Assumes both ends share aclk; strobes are sampled on its rising edge.
`timescale 1ns/100ps
`default_nettype none
interface uei_link_if;
  logic rd; // One-cycle read strobe.
  logic wr; // One-cycle write strobe.
  logic [4:0] addr; // Register address.
  logic [7:0] wdata; // Write data.
  logic [7:0] rdata; // Read data, valid the cycle after rd.
  logic irq_func; // Summary function interrupt level.
  logic irq_sof; // Start-of-frame pulse.
  modport dev (input rd, wr, addr, wdata, output rdata, irq_func, irq_sof);
  modport ctl (output rd, wr, addr, wdata, input rdata, irq_func, irq_sof);
endinterface
`default_nettype wire

// File: design/uei_dev.sv
// USB function endpoint interrupt flags and transmit buffer control.
// Assumes the bus engine delivers one event per cycle, tagged by ev_ep.
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "uei_map.svh"
module uei_dev
  import uei_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int SUSP_CYC = `UEI_SUSP_CYC,
  parameter int SE0_CYC = `UEI_SE0_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  uei_link_if.dev lk,
  input wire logic line_idle,
  input wire logic line_se0,
  input wire logic sof_rcvd,
  input wire logic [2:0] ev_ep,
  input wire logic rx_byte,
  input wire logic rx_ok,
  input wire logic rx_fail,
  input wire logic tx_start,
  input wire logic tx_rd,
  input wire logic tx_ack,
  input wire logic tx_fail,
  input wire logic stall_set,
  input wire logic setup_end_set,
  input wire logic data_end_clr,
  output logic [7:0] tx_data,
  output logic tx_has_data
);
  // ==========================================================================
  // State
  // ==========================================================================
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(SUSP_CYC + SE0_CYC + 1);
  localparam int NEP = `UEI_NEP;
  typedef struct packed {
    logic [2:0] idx; // Endpoint index for buffer and control accesses.
    logic [7:0] st1; // Control endpoint and transmit flags.
    logic [7:0] st2; // Receive, overrun, reset, resume, suspend flags.
    logic [7:0] ien1; // Enables for status one.
    logic [7:0] ien2; // Enables for status two.
    logic [7:0] ica; // Control register A.
    logic [NEP-1:0] iso; // Isochronous endpoint marks.
    logic [NEP-1:0][7:0] max_packet_size; // Maximum packet size per endpoint.
    logic [NEP-1:0][1:0] tpk; // Committed transmit packets.
    logic [NEP-1:0][PW-1:0] twp; // Transmit write pointers.
    logic [NEP-1:0][PW-1:0] trp; // Transmit read pointers.
    logic [NEP-1:0][PW-1:0] tsp; // Start of the current transmit set.
    logic [NEP-1:0][1:0] rpk; // Received packets awaiting unload.
    logic [NEP-1:0][PW-1:0] rwp; // Receive write pointers.
    logic [NEP-1:0][PW-1:0] rsp; // Start of the current receive set.
    logic [NEP-1:0] ttog; // Transmit data toggles.
    logic [NEP-1:0] rtog; // Receive data toggles.
    logic [NEP-1:0][DEPTH-1:0][7:0] mem; // Transmit buffers.
    logic susp; // Suspended.
    logic [CW-1:0] icnt; // Idle bus cycles.
    logic [CW-1:0] zcnt; // SE0 cycles.
    logic [7:0] rdata; // Link read data.
    logic [7:0] txd; // Byte to the serialiser.
    logic sof; // Start-of-frame interrupt pulse.
  } dev_st_t;
  dev_st_t s_q, s_d;

  // Dual packet mode test for one endpoint.
  function automatic logic uei_dual(input logic [7:0] mp, input logic [2:0] ep);
    uei_dual = (ep != 3'h0) && (mp <= 8'(DEPTH / 2));
  endfunction

  // Packet-ready as seen by the processor.
  function automatic logic uei_rdy(input logic [1:0] pk, input logic dual);
    uei_rdy = dual ? (pk == 2'h2) : (pk != 2'h0);
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Processor writes are applied first so that hardware sets win over clears.
  always_comb begin
    logic [2:0] i;
    logic [2:0] e;
    logic ev_ok;
    logic [CW-1:0] zkeep;
    s_d = s_q;
    i = s_q.idx;
    e = ev_ep;
    ev_ok = (ev_ep < 3'(NEP));
    zkeep = s_q.zcnt;
    s_d.sof = sof_rcvd & s_q.ica[`UEI_ICA_SOF];
    // Link read: data appears one cycle after the strobe; unmapped reads zero.
    if (lk.rd) begin
      unique case (lk.addr)
        `UEI_R_IDX: s_d.rdata = {5'h00, s_q.idx};
        `UEI_R_ST1: s_d.rdata = s_q.st1;
        `UEI_R_ST2: s_d.rdata = s_q.st2;
        `UEI_R_IEN1: s_d.rdata = s_q.ien1;
        `UEI_R_IEN2: s_d.rdata = s_q.ien2;
        `UEI_R_IRQ_CONTROL_A: s_d.rdata = s_q.ica;
        `UEI_R_TXCSR: s_d.rdata = {6'h00, s_q.tpk[i] != 2'h0,
          uei_rdy(s_q.tpk[i], uei_dual(s_q.max_packet_size[i], i))};
        `UEI_R_RXCSR: s_d.rdata = {7'h00, s_q.rpk[i] != 2'h0};
        `UEI_R_MAX_PACKET_SIZE: s_d.rdata = s_q.max_packet_size[i];
        `UEI_R_ISO: s_d.rdata = 8'(s_q.iso);
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Link write.
    if (lk.wr) begin
      unique case (lk.addr)
        `UEI_R_IDX: s_d.idx = lk.wdata[2:0];
        `UEI_R_ST1: s_d.st1 = s_q.st1 & ~lk.wdata;
        `UEI_R_ST2: s_d.st2 = s_q.st2 & ~lk.wdata;
        `UEI_R_IEN1: s_d.ien1 = lk.wdata;
        `UEI_R_IEN2: s_d.ien2 = lk.wdata;
        `UEI_R_IRQ_CONTROL_A: s_d.ica = lk.wdata;
        `UEI_R_TXCSR: begin
          // Processor commits one loaded packet.
          if (i < 3'(NEP) && lk.wdata[`UEI_CSR_RDY] && s_q.tpk[i] != 2'h2) begin
            s_d.tpk[i] = s_q.tpk[i] + 2'h1;
          end
        end
        `UEI_R_RXCSR: begin
          // Writing zero releases the oldest unloaded packet.
          if (i < 3'(NEP) && !lk.wdata[`UEI_CSR_RDY] && s_q.rpk[i] != 2'h0) begin
            s_d.rpk[i] = s_q.rpk[i] - 2'h1;
          end
        end
        `UEI_R_MAX_PACKET_SIZE: if (i < 3'(NEP)) s_d.max_packet_size[i] = lk.wdata;
        `UEI_R_TXDATA: begin
          if (i < 3'(NEP)) begin
            s_d.mem[i][s_q.twp[i]] = lk.wdata;
            s_d.twp[i] = s_q.twp[i] + 1'b1;
          end
        end
        `UEI_R_ISO: s_d.iso = lk.wdata[NEP-1:0];
        default: s_d.idx = s_q.idx;
      endcase
    end
    // Bus events from the serial engine.
    if (ev_ok) begin
      if (tx_rd) begin
        s_d.txd = s_q.mem[e][s_q.trp[e]];
        s_d.trp[e] = s_q.trp[e] + 1'b1;
      end
      if (tx_start && s_q.iso[e] && s_q.tpk[e] == 2'h0) begin
        s_d.st2[`UEI_ST2_OVR] = 1'b1;
        if (e != 3'h0) s_d.st1[e] = 1'b1;
      end
      if (tx_ack) begin
        // Host acknowledged: the set is spent and room frees at once.
        if (s_q.tpk[e] != 2'h0) s_d.tpk[e] = s_q.tpk[e] - 2'h1;
        s_d.tsp[e] = s_q.trp[e];
        s_d.ttog[e] = ~s_q.ttog[e];
        s_d.st1[e] = 1'b1;
      end
      if (tx_fail) s_d.trp[e] = s_q.tsp[e];
      if (rx_byte) s_d.rwp[e] = s_q.rwp[e] + 1'b1;
      if (rx_fail) s_d.rwp[e] = s_q.rsp[e];
      if (rx_ok) begin
        if (s_q.iso[e] && s_q.rpk[e] == (uei_dual(s_q.max_packet_size[e], e) ? 2'h2 : 2'h1)) begin
          // No room: the packet is dropped and overrun is flagged.
          s_d.rwp[e] = s_q.rsp[e];
          s_d.st2[`UEI_ST2_OVR] = 1'b1;
        end else begin
          s_d.rpk[e] = s_q.rpk[e] + 2'h1;
          s_d.rsp[e] = s_q.rwp[e];
          s_d.rtog[e] = ~s_q.rtog[e];
        end
        if (e == 3'h0) s_d.st1[0] = 1'b1;
        else s_d.st2[e-3'h1] = 1'b1;
      end
      if (stall_set) begin
        if (e == 3'h0) s_d.st1[0] = 1'b1;
        else s_d.st2[e-3'h1] = 1'b1;
      end
    end
    if (setup_end_set) begin
      s_d.tpk[0] = 2'h0;
      s_d.st1[0] = 1'b1;
    end
    if (data_end_clr) s_d.st1[0] = 1'b1;
    // Idle-bus timer and resume detection.
    if (line_idle) begin
      if (s_q.icnt != CW'(SUSP_CYC)) s_d.icnt = s_q.icnt + 1'b1;
      if (s_q.icnt == CW'(SUSP_CYC - 1)) begin
        s_d.st2[`UEI_ST2_SUS] = 1'b1;
        s_d.susp = 1'b1;
      end
    end else begin
      s_d.icnt = '0;
      if (s_q.susp) begin
        s_d.susp = 1'b0;
        s_d.st2[`UEI_ST2_RES] = 1'b1;
      end
    end
    // SE0 timer; on expiry everything but the reset flag and the SE0 count returns to default.
    if (line_se0) begin
      if (s_q.zcnt != CW'(SE0_CYC)) begin
        zkeep = s_q.zcnt + 1'b1;
      end
      s_d.zcnt = zkeep;
      if (s_q.zcnt == CW'(SE0_CYC - 1)) begin
        s_d = '0;
        s_d.zcnt = zkeep;
        s_d.st2[`UEI_ST2_RST] = 1'b1;
      end
    end else begin
      s_d.zcnt = '0;
    end
  end

  // Register the whole state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Reset and resume have no enable; suspend uses enable-two bit seven.
  assign lk.irq_func = s_q.ica[`UEI_ICA_FUNC] & (|(s_q.st1 & s_q.ien1)
    | |(s_q.st2 & {s_q.ien2[7], 2'b11, s_q.ien2[4:0]}));
  assign lk.irq_sof = s_q.sof;
  assign lk.rdata = s_q.rdata;
  assign tx_data = s_q.txd;
  assign tx_has_data = (ev_ep < 3'(NEP)) ? (s_q.tpk[ev_ep] != 2'h0) : 1'b0;
endmodule
`default_nettype wire

// File: design/uei_ctl.sv
// Processor-side controller: AXI4-Lite registers driving the device link.
// Assumes an AXI4-Lite master on aclk and the device on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "uei_map.svh"
module uei_ctl
  import uei_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  uei_link_if.ctl lk,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    uei_hst_t st; // Sequencer state.
    logic [4:0] addr; // Link address.
    logic [7:0] wdata; // Link write data.
    logic [31:0] cmd; // Last command word.
    logic [7:0] last; // Last read result.
    logic refused; // Last command was refused.
    logic reinit; // Bus reset seen; core needs reinitialising.
    logic [7:0] s1; // Captured status one.
    logic [7:0] s2; // Captured status two.
    logic aw_got; // Write address held.
    logic [AW-1:0] awaddr;
    logic w_got; // Write data held.
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ctl_st_t;
  ctl_st_t s_q, s_d;

  // Merge a write word into an old one under byte strobes.
  function automatic logic [31:0] uei_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] b);
    for (int k = 0; k < 4; k++) begin
      o[8*k +: 8] = b[k] ? n[8*k +: 8] : o[8*k +: 8];
    end
    uei_merge = o;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [31:0] c;
    s_d = s_q;
    c = uei_merge(s_q.cmd, s_q.wd, s_q.ws);
    // Capture write address and data in either order.
    if (s_axi_awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.wd = s_axi_wdata;
      s_d.ws = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
    if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
    // Read channel: answer one cycle after the address is taken.
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `UEI_AXI_OKAY;
      unique case (s_axi_araddr)
        `UEI_A_CMD: s_d.rdata = s_q.cmd;
        `UEI_A_STAT: s_d.rdata = {19'h0, lk.irq_sof, lk.irq_func, s_q.reinit, s_q.refused,
          s_q.st != UEI_IDLE, s_q.last};
        `UEI_A_ISR: s_d.rdata = {16'h0, s_q.s2, s_q.s1};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = `UEI_AXI_SLVERR;
        end
      endcase
    end
    // Sequencer.
    unique case (s_q.st)
      UEI_IDLE: s_d.st = UEI_IDLE;
      UEI_CRD: s_d.st = UEI_CHK;
      UEI_CHK: begin
        if (lk.rdata[`UEI_CSR_RDY]) begin
          s_d.refused = 1'b1;
          s_d.st = UEI_IDLE;
        end else begin
          s_d.addr = `UEI_R_TXDATA;
          s_d.st = UEI_AWR;
        end
      end
      UEI_AWR: s_d.st = UEI_IDLE;
      UEI_ARD: s_d.st = UEI_RDN;
      UEI_RDN: begin
        s_d.last = lk.rdata;
        s_d.st = UEI_IDLE;
      end
      UEI_SR1: begin
        s_d.addr = `UEI_R_ST2;
        s_d.st = UEI_SR2;
      end
      UEI_SR2: begin
        s_d.s1 = lk.rdata;
        s_d.addr = `UEI_R_ST1;
        s_d.wdata = lk.rdata;
        s_d.st = UEI_SW1;
      end
      UEI_SW1: begin
        s_d.s2 = lk.rdata;
        s_d.addr = `UEI_R_ST2;
        s_d.wdata = lk.rdata;
        if (lk.rdata[`UEI_ST2_RST]) s_d.reinit = 1'b1;
        s_d.st = UEI_SW2;
      end
      UEI_SW2: s_d.st = UEI_IDLE;
      default: s_d.st = UEI_IDLE;
    endcase
    // Write response once both halves are held; a command starts the sequencer if it is idle, else it is refused.
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `UEI_AXI_OKAY;
      if (s_q.awaddr == `UEI_A_CMD) begin
        if (c[`UEI_CMD_CLRI]) s_d.reinit = 1'b0;
        if (s_q.st != UEI_IDLE) begin
          s_d.refused = 1'b1;
        end else begin
          s_d.cmd = c;
          s_d.refused = 1'b0;
          s_d.addr = c[4:0];
          s_d.wdata = c[15:8];
          if (c[`UEI_CMD_SVC]) begin
            s_d.addr = `UEI_R_ST1;
            s_d.st = UEI_SR1;
          end else if (c[`UEI_CMD_WR] && c[4:0] == `UEI_R_TXDATA) begin
            s_d.addr = `UEI_R_TXCSR;
            s_d.st = UEI_CRD;
          end else begin
            s_d.st = c[`UEI_CMD_WR] ? UEI_AWR : UEI_ARD;
          end
        end
      end else begin
        s_d.bresp = `UEI_AXI_SLVERR;
      end
    end
  end

  // Register the whole state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign lk.rd = (s_q.st == UEI_CRD) || (s_q.st == UEI_ARD) || (s_q.st == UEI_SR1) || (s_q.st == UEI_SR2);
  assign lk.wr = (s_q.st == UEI_AWR) || (s_q.st == UEI_SW1) || (s_q.st == UEI_SW2);
  assign lk.addr = s_q.addr;
  assign lk.wdata = s_q.wdata;
  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready = !s_q.w_got;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
endmodule
`default_nettype wire

// File: sim/uei_link_props.sv
// Link checker for the endpoint interrupt block.
// Assumes the signals of the one link that joins controller and device.
`timescale 1ns/100ps
`default_nettype none
`include "uei_map.svh"
module uei_link_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rd,
  input wire logic wr,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic irq_func,
  input wire logic irq_sof
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] ica_q; // Last control A value written.
  logic [7:0] ien2_q; // Last enable two value written.
  logic st1_q; // Status one written back, status two not yet.
  logic csr_q; // Transmit control word read last cycle.
  logic ok_q; // Last transmit control word showed ready low.
  // Mirrors what the controller wrote, so reads can be judged.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ica_q <= 8'h00;
      ien2_q <= 8'h00;
      st1_q <= 1'h0;
      csr_q <= 1'h0;
      ok_q <= 1'h0;
    end else begin
      csr_q <= rd && addr == `UEI_R_TXCSR;
      if (csr_q) ok_q <= !rdata[`UEI_CSR_RDY];
      if (wr && addr == `UEI_R_IRQ_CONTROL_A) ica_q <= wdata;
      if (wr && addr == `UEI_R_IEN2) ien2_q <= wdata;
      if (wr && addr == `UEI_R_ST1) st1_q <= 1'h1;
      else if (wr && addr == `UEI_R_ST2) st1_q <= 1'h0;
    end
  end
  property p_st1_first; wr && addr == `UEI_R_ST2 |-> st1_q; endproperty
  a_st1_first: assert property (p_st1_first) else $error("status two written first");
  property p_st2_next; wr && addr == `UEI_R_ST1 |-> ##[1:8] (wr && addr == `UEI_R_ST2); endproperty
  a_st2_next: assert property (p_st2_next) else $error("status two not written");
  property p_func_gate; !ica_q[`UEI_ICA_FUNC] |-> !irq_func; endproperty
  a_func_gate: assert property (p_func_gate) else $error("function request not gated");
  property p_sof_gate; !ica_q[`UEI_ICA_SOF] |-> !irq_sof; endproperty
  a_sof_gate: assert property (p_sof_gate) else $error("frame request not gated");
  property p_sof_pulse; irq_sof |=> !irq_sof; endproperty
  a_sof_pulse: assert property (p_sof_pulse) else $error("frame request too long");
  property p_tx_guard; wr && addr == `UEI_R_TXDATA |-> ok_q; endproperty
  a_tx_guard: assert property (p_tx_guard) else $error("buffer written while ready");
  property p_ica_keep; rd && addr == `UEI_R_IRQ_CONTROL_A |=> rdata[1:0] == ica_q[1:0]; endproperty
  a_ica_keep: assert property (p_ica_keep) else $error("control A lost");
  property p_ien2_keep; rd && addr == `UEI_R_IEN2 |=> rdata[7] == ien2_q[7]; endproperty
  a_ien2_keep: assert property (p_ien2_keep) else $error("suspend enable lost");
endmodule
`default_nettype wire

// File: sim/usb_endpoint_irq_in_fifo_ctrl_bench.sv
// Bench: AXI4-Lite master on the controller, bus events on the device.
// Assumes both design ends, the link interface and the register map.
`timescale 1ns/100ps
`default_nettype none
`include "uei_map.svh"
module usb_endpoint_irq_in_fifo_ctrl_bench;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, tx_has_data, rd_d = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, r, tx_data, bb [3];
  logic [31:0] wdata = 32'h0, rdata, v, eq [$], mq [$];
  logic [1:0] bresp, rresp, bq [$];
  logic line_idle = 1'h0, line_se0 = 1'h0, sof = 1'h0;
  logic [2:0] ev_ep = 3'h0;
  logic [9:0] evs = 10'h000;
  int error_cnt = 0, checked = 0, cyc = 0, sof_cnt = 0, k0 [5] = '{1, 5, 7, 8, 9};
  logic [7:0] tq [$];
  uei_link_if lk ();
  uei_ctl uei_ctl_i (.aclk(aclk), .aresetn(aresetn), .lk(lk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  uei_dev #(.DEPTH(16), .SUSP_CYC(40), .SE0_CYC(30)) uei_dev_i (.aclk(aclk), .aresetn(aresetn), .lk(lk),
    .line_idle(line_idle), .line_se0(line_se0), .sof_rcvd(sof), .ev_ep(ev_ep), .rx_byte(evs[0]), .rx_ok(evs[1]),
    .rx_fail(evs[2]), .tx_start(evs[3]), .tx_rd(evs[4]), .tx_ack(evs[5]), .tx_fail(evs[6]), .stall_set(evs[7]),
    .setup_end_set(evs[8]), .data_end_clr(evs[9]), .tx_data(tx_data), .tx_has_data(tx_has_data));
  uei_link_props uei_link_props_i (.aclk(aclk), .aresetn(aresetn), .rd(lk.rd), .wr(lk.wr), .addr(lk.addr),
    .wdata(lk.wdata), .rdata(lk.rdata), .irq_func(lk.irq_func), .irq_sof(lk.irq_sof));
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic cmp(input logic [31:0] e, m, g);
    checked++;
    if (((g ^ e) & m) !== 32'h0) begin
      error_cnt++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Monitor: each answer takes the oldest note and is compared.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    rd_d <= evs[4];
    if (rvalid && rready) cmp(eq.pop_front(), mq.pop_front(), rdata);
    if (bvalid && bready) cmp({30'h0, bq.pop_front()}, 32'h3, {30'h0, bresp});
    if (rvalid && rready) cmp(32'h0, 32'h3, {30'h0, rresp});
    if (rd_d) cmp({24'h0, tq.pop_front()}, 32'hFF, {24'h0, tx_data});
    if (lk.irq_sof) sof_cnt++;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, m);
    eq.push_back(e);
    mq.push_back(m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    v = rdata;
    rready <= 1'h0;
  endtask
  // Issues one command and waits until the controller is no longer busy.
  task automatic cmd(input logic [31:0] c);
    axw(`UEI_A_CMD, c, `UEI_AXI_OKAY);
    do axr(`UEI_A_STAT, 32'h0, 32'h0); while (v[8] !== 1'h0);
  endtask
  task automatic dw(input logic [4:0] a, input logic [7:0] d);
    cmd({15'h0, 1'h1, d, 3'h0, a});
  endtask
  task automatic dr(input logic [4:0] a, input logic [7:0] e, m);
    cmd({27'h0, a});
    axr(`UEI_A_STAT, {24'h0, e}, {24'h0, m});
  endtask
  task automatic svc(input logic [15:0] e);
    cmd(32'h0002_0000);
    axr(`UEI_A_ISR, {16'h0, e}, 32'hFFFF);
  endtask
  task automatic ev(input int k, input logic [2:0] e);
    @(posedge aclk);
    ev_ep <= e;
    evs <= 10'h001 << k;
    @(posedge aclk);
    evs <= 10'h000;
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask
  initial begin
    void'($urandom(27));
    hold(5);
    aresetn <= 1'h1;
    axw(8'h40, 32'h0, `UEI_AXI_SLVERR);
    r = 8'($urandom);
    dw(`UEI_R_IEN1, r);
    dr(`UEI_R_IEN1, r, 8'hFF);
    dw(`UEI_R_IRQ_CONTROL_A, 8'h01);
    ev(1, 3'h1);
    axr(`UEI_A_STAT, 32'h0, 32'h800);
    dw(`UEI_R_IEN2, 8'h01);
    dr(`UEI_R_IEN2, 8'h01, 8'h9F);
    axr(`UEI_A_STAT, 32'h800, 32'h800);
    dw(`UEI_R_IRQ_CONTROL_A, 8'h00);
    dr(`UEI_R_IRQ_CONTROL_A, 8'h00, 8'h03);
    svc(16'h0100);
    svc(16'h0000);
    for (int e = 1; e < 5; e++) begin
      ev(1, 3'(e));
      svc({8'h1 << (e - 1), 8'h0});
      ev(7, 3'(e));
      svc({8'h1 << (e - 1), 8'h0});
    end
    for (int i = 0; i < 5; i++) begin
      ev(k0[i], 3'h0);
      svc(16'h0001);
    end
    dw(`UEI_R_ISO, 8'h1E);
    for (int e = 1; e < 5; e++) begin
      ev(3, 3'(e));
      svc({8'h10, 8'h1 << e});
    end
    ev(1, 3'h1);
    svc(16'h1100);
    dw(`UEI_R_ISO, 8'h00);
    dw(`UEI_R_IDX, 8'h02);
    for (int i = 0; i < 3; i++) begin
      bb[i] = 8'($urandom);
      tq.push_back(bb[i]);
      dw(`UEI_R_TXDATA, bb[i]);
    end
    dw(`UEI_R_TXCSR, 8'h01);
    dr(`UEI_R_TXCSR, 8'h02, 8'h03);
    dw(`UEI_R_TXCSR, 8'h01);
    dr(`UEI_R_TXCSR, 8'h03, 8'h03);
    dw(`UEI_R_TXDATA, 8'h5A);
    axr(`UEI_A_STAT, 32'h200, 32'h200);
    for (int i = 0; i < 3; i++) ev(4, 3'h2);
    for (int i = 0; i < 3; i++) tq.push_back(bb[i]);
    ev(6, 3'h2);
    for (int i = 0; i < 3; i++) ev(4, 3'h2);
    ev(5, 3'h2);
    dr(`UEI_R_TXCSR, 8'h02, 8'h03);
    cmp(32'h1, 32'h1, {31'h0, tx_has_data});
    svc(16'h0004);
    dw(`UEI_R_IDX, 8'h03);
    dw(`UEI_R_MAX_PACKET_SIZE, 8'h10);
    dw(`UEI_R_TXCSR, 8'h01);
    dr(`UEI_R_TXCSR, 8'h01, 8'h01);
    ev(5, 3'h3);
    dr(`UEI_R_TXCSR, 8'h00, 8'h01);
    cmp(32'h0, 32'h1, {31'h0, tx_has_data});
    svc(16'h0008);
    dw(`UEI_R_IDX, 8'h00);
    dw(`UEI_R_TXCSR, 8'h01);
    dr(`UEI_R_TXCSR, 8'h01, 8'h01);
    ev(8, 3'h0);
    dr(`UEI_R_TXCSR, 8'h00, 8'h01);
    svc(16'h0001);
    dw(`UEI_R_IRQ_CONTROL_A, 8'h01);
    dw(`UEI_R_IEN2, 8'h00);
    line_idle <= 1'h1;
    hold(39);
    line_idle <= 1'h0;
    svc(16'h0000);
    line_idle <= 1'h1;
    hold(45);
    axr(`UEI_A_STAT, 32'h0, 32'h800);
    dw(`UEI_R_IEN2, 8'h80);
    axr(`UEI_A_STAT, 32'h800, 32'h800);
    line_idle <= 1'h0;
    svc(16'hC000);
    dw(`UEI_R_IEN1, 8'hFF);
    line_se0 <= 1'h1;
    hold(29);
    line_se0 <= 1'h0;
    svc(16'h0000);
    line_se0 <= 1'h1;
    hold(35);
    line_se0 <= 1'h0;
    dr(`UEI_R_IEN1, 8'h00, 8'hFF);
    svc(16'h2000);
    axr(`UEI_A_STAT, 32'h400, 32'h400);
    cmd(32'h0004_0000);
    axr(`UEI_A_STAT, 32'h0, 32'h400);
    for (int i = 0; i < 4; i++) begin
      if (i == 1) dw(`UEI_R_IRQ_CONTROL_A, 8'h02);
      sof <= 1'h1;
      hold(1);
      sof <= 1'h0;
      hold(3);
    end
    cmp(32'h3, 32'hFF, 32'(sof_cnt));
    close_out();
  end
endmodule
`default_nettype wire
